// ==== design/smartcard_alt_control.sv ====
// alternate control bank: timers, sequence triggers, path resets, wishbone
//
// Our own choices: the Wishbone interface to the registers and the address map.
module smartcard_alt_control (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // wishbone classic slave
    input wire smartcard_alt_pkg::wb_req_t wbReq,
    output logic wbAck,
    output logic [31:0] wbDat,
    // card contact controls
    output smartcard_alt_pkg::card_pins_t cardPins,
    // path resets toward transmit and receive buffers
    output logic txPathReset,
    output logic rxPathReset,
    // interrupt
    output logic irq
);
    import smartcard_alt_pkg::*;

    // ======================================================================
    // bus decode
    logic strobe;
    logic wr;
    logic [31:0] mainCtl;
    logic [31:0] tmrCtl [3];
    logic [31:0] stsReg;
    logic [31:0] ienReg;
    logic [31:0] altRead;
    logic [31:0] altMerged;
    logic altWrite;
    logic ctlEnable;
    logic pathSet;
    logic [2:0] run;
    logic [2:0] timerDone;
    logic [1:0] pathBusy;
    logic [2:0] trig;
    logic [2:0] trigSet;
    logic [2:0] trigDone;
    logic [1:0] syncCnt;
    logic seqDone;
    seq_state_t seqState;
    seq_kind_t seqKind;

    function automatic logic [31:0] merge(input logic [31:0] cur,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = cur;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = dat[8*b +: 8];
            end
        end
        return res;
    endfunction

    assign strobe = wbReq.cyc & wbReq.stb & ~wbAck;
    assign wr = strobe & wbReq.we;
    assign altWrite = wr && (wbReq.adr == OFF_ALT);
    assign ctlEnable = mainCtl[MAIN_EN_BIT];
    assign altMerged = merge(altRead, wbReq.dat, wbReq.sel);
    // either path reset bit written as 1
    assign pathSet = altWrite & (altMerged[ALT_TX_RST_BIT]
                                 | altMerged[ALT_RX_RST_BIT]);

    always_ff @(posedge clock) begin
        if (srst) begin
            wbAck <= 1'b0;
        end else begin
            wbAck <= strobe;
        end
    end

    always_comb begin
        altRead = REG_RESET;
        altRead[ALT_SYNC_BIT] = (syncCnt != 2'h0);
        altRead[ALT_ACTIVE_LO +: 3] = run;
        altRead[ALT_RUN_LO +: 3] = run;
        altRead[ALT_WARM_BIT] = trig[1];
        altRead[ALT_ACT_BIT] = trig[0];
        altRead[ALT_DEACT_BIT] = trig[2];
        altRead[ALT_RX_RST_BIT] = pathBusy[1];
        altRead[ALT_TX_RST_BIT] = pathBusy[0];
    end

    // unmapped and write-only offsets read as zero
    always_ff @(posedge clock) begin
        if (srst) begin
            wbDat <= REG_RESET;
        end else if (strobe) begin
            case (wbReq.adr)
                OFF_MAIN: wbDat <= mainCtl;
                OFF_ALT: wbDat <= altRead;
                OFF_TMR0: wbDat <= tmrCtl[0];
                OFF_TMR1: wbDat <= tmrCtl[1];
                OFF_TMR2: wbDat <= tmrCtl[2];
                OFF_STS: wbDat <= stsReg;
                OFF_IEN: wbDat <= ienReg;
                default: wbDat <= REG_RESET;
            endcase
        end
    end

    // ======================================================================
    // plain read/write registers
    always_ff @(posedge clock) begin
        if (srst) begin
            mainCtl <= REG_RESET;
            ienReg <= REG_RESET;
        end else if (wr) begin
            if (wbReq.adr == OFF_MAIN) begin
                mainCtl <= merge(mainCtl, wbReq.dat, wbReq.sel);
            end
            if (wbReq.adr == OFF_IEN) begin
                ienReg <= merge(ienReg, wbReq.dat, wbReq.sel);
            end
        end
    end

    // write tracking: the flag covers the settling time of the bank
    always_ff @(posedge clock) begin
        if (srst) begin
            syncCnt <= 2'h0;
        end else if (altWrite) begin
            syncCnt <= SYNC_CYCLES;
        end else if (syncCnt != 2'h0) begin
            syncCnt <= syncCnt - 2'h1;
        end
    end

    // ======================================================================
    // etu divider shared by the three timers
    logic [11:0] etuCnt;
    logic etuTick;
    assign etuTick = (etuCnt == ETU_DIV);

    always_ff @(posedge clock) begin
        if (srst || etuTick) begin
            etuCnt <= 12'h000;
        end else begin
            etuCnt <= etuCnt + 12'h001;
        end
    end

    // ======================================================================
    // internal timers; selection field is software's concern, not checked
    // here since the timer path itself does not see it
    for (genvar i = 0; i < 3; i++) begin : g_timer
        logic [23:0] count;
        logic [23:0] reload;
        logic [7:0] tmrOff;
        logic runWrite;
        assign tmrOff = OFF_TMR0 + 8'(4 * i);
        // timer0 is 24 bits wide, the other two 8 bits
        assign reload = (i == 0) ? tmrCtl[i][23:0]
                                 : {16'h0000, tmrCtl[i][7:0]};
        assign runWrite = altWrite & ctlEnable;
        assign timerDone[i] = run[i] & etuTick & (count <= 24'h000001);

        always_ff @(posedge clock) begin
            if (srst) begin
                tmrCtl[i] <= REG_RESET;
            end else if (wr && (wbReq.adr == tmrOff)) begin
                tmrCtl[i] <= merge(tmrCtl[i], wbReq.dat, wbReq.sel);
            end
        end

        always_ff @(posedge clock) begin
            if (srst) begin
                run[i] <= 1'b0;
                count <= 24'h000000;
            end else if (runWrite) begin
                run[i] <= altMerged[ALT_RUN_LO + i];
                count <= reload;
            end else if (timerDone[i]) begin
                count <= reload;
                if (!tmrCtl[i][TMR_RELOAD_BIT]) begin
                    run[i] <= 1'b0;
                end
            end else if (run[i] && etuTick) begin
                count <= count - 24'h000001;
            end
        end
    end

    // ======================================================================
    // path resets: level held for a fixed count, then the bit falls back
    for (genvar p = 0; p < 2; p++) begin : g_path
        logic [3:0] cnt;
        always_ff @(posedge clock) begin
            if (srst) begin
                pathBusy[p] <= 1'b0;
                cnt <= 4'h0;
            end else if (altWrite && altMerged[ALT_TX_RST_BIT + p]) begin
                pathBusy[p] <= 1'b1;
                cnt <= PATH_RESET_CYCLES - 4'h1;
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else begin
                pathBusy[p] <= 1'b0;
            end
        end
    end

    assign txPathReset = pathBusy[0];
    assign rxPathReset = pathBusy[1];

    // ======================================================================
    // sequence triggers: bit0 activation, bit1 warm reset, bit2 deactivation
    always_comb begin
        trigSet = '0;
        if (altWrite && ctlEnable) begin
            trigSet[0] = altMerged[ALT_ACT_BIT];
            trigSet[1] = altMerged[ALT_WARM_BIT];
            trigSet[2] = altMerged[ALT_DEACT_BIT];
        end
        trigDone = '0;
        if (seqDone) begin
            case (seqKind)
                KIND_ACT: trigDone[0] = 1'b1;
                KIND_WARM: trigDone[1] = 1'b1;
                KIND_DEACT: trigDone[2] = 1'b1;
                default: trigDone = '0;
            endcase
        end
    end

    // a fresh write wins over completion in the same cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            trig <= 3'h0;
        end else if (pathSet) begin
            trig <= 3'h0;
        end else begin
            trig <= (trig & ~trigDone) | trigSet;
        end
    end

    // ======================================================================
    // sequencer: three phases of fixed length per kind
    logic [15:0] phaseCnt;
    logic phaseEnd;
    logic kindLive;
    assign phaseEnd = (phaseCnt == 16'h0000);
    assign seqDone = (seqState == SEQ_PH3) && phaseEnd && kindLive && !pathSet;

    always_comb begin
        case (seqKind)
            KIND_ACT: kindLive = trig[0];
            KIND_WARM: kindLive = trig[1];
            KIND_DEACT: kindLive = trig[2];
            default: kindLive = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            seqState <= SEQ_IDLE;
            seqKind <= KIND_ACT;
            phaseCnt <= 16'h0000;
        end else begin
            case (seqState)
                SEQ_IDLE: begin
                    phaseCnt <= SEQ_PHASE_CYCLES;
                    if (!pathSet && trig != 3'h0) begin
                        seqState <= SEQ_PH1;
                        // deactivation outranks activation outranks warm
                        if (trig[2]) begin
                            seqKind <= KIND_DEACT;
                        end else if (trig[0]) begin
                            seqKind <= KIND_ACT;
                        end else begin
                            seqKind <= KIND_WARM;
                        end
                    end
                end
                SEQ_PH1, SEQ_PH2, SEQ_PH3: begin
                    if (!kindLive || pathSet) begin
                        seqState <= SEQ_IDLE;
                    end else if (phaseEnd) begin
                        phaseCnt <= SEQ_PHASE_CYCLES;
                        if (seqState == SEQ_PH1) begin
                            seqState <= SEQ_PH2;
                        end else if (seqState == SEQ_PH2) begin
                            seqState <= SEQ_PH3;
                        end else begin
                            seqState <= SEQ_IDLE;
                        end
                    end else begin
                        phaseCnt <= phaseCnt - 16'h0001;
                    end
                end
                default: seqState <= SEQ_IDLE;
            endcase
        end
    end

    // contact levels move on phase entry, reset rises at the end of phase 3 for activation and warm reset; an aborted sequence leaves them
    always_ff @(posedge clock) begin
        if (srst) begin
            cardPins <= '0;
        end else if (seqState != SEQ_IDLE && kindLive && !pathSet) begin
            case (seqKind)
                KIND_ACT: begin
                    cardPins.power <= 1'b1;
                    cardPins.clkEn <= (seqState != SEQ_PH1);
                    cardPins.rstHigh <= (seqState == SEQ_PH3) && phaseEnd;
                end
                KIND_WARM: begin
                    cardPins.rstHigh <= (seqState == SEQ_PH3) && phaseEnd;
                end
                KIND_DEACT: begin
                    cardPins.rstHigh <= 1'b0;
                    if (seqState != SEQ_PH1) begin
                        cardPins.clkEn <= 1'b0;
                    end
                    if (seqState == SEQ_PH3) begin
                        cardPins.power <= 1'b0;
                    end
                end
                default: cardPins <= cardPins;
            endcase
        end
    end

    // ======================================================================
    // interrupt status: sticky, write-one-to-clear, set wins
    logic [31:0] stsEvents;
    logic [31:0] stsClear;
    always_comb begin
        stsEvents = REG_RESET;
        stsEvents[STS_TMR_LO +: 3] = timerDone;
        stsEvents[STS_INIT_BIT] = seqDone;
        stsClear = REG_RESET;
        if (wr && wbReq.adr == OFF_CLR) begin
            stsClear = merge(REG_RESET, wbReq.dat, wbReq.sel);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            stsReg <= REG_RESET;
        end else begin
            stsReg <= (stsReg & ~stsClear) | stsEvents;
        end
    end

    assign irq = |(stsReg & ienReg);

    // ======================================================================
    // checks
    a_run_start: assert property (@(posedge clock) disable iff (srst)
        altWrite && ctlEnable && altMerged[ALT_RUN_LO] |=> run[0])
        else $error("timer0 did not start on write of 1");
    a_run_stop: assert property (@(posedge clock) disable iff (srst)
        altWrite && ctlEnable && !altMerged[ALT_RUN_LO + 1]
        |=> !run[1])
        else $error("timer1 did not stop on write of 0");
    a_oneshot_clear: assert property (@(posedge clock) disable iff (srst)
        timerDone[2] && !tmrCtl[2][TMR_RELOAD_BIT] && !altWrite
        |=> !run[2])
        else $error("one-shot timer2 kept running after expiry");
    a_gate_disabled: assert property (@(posedge clock) disable iff (srst)
        altWrite && !ctlEnable && !pathSet && !seqDone
        |=> $stable(trig) && (run == ($past(run) & ~$past(timerDone))))
        else $error("trigger or run bit changed while disabled");
    a_zero_noeffect: assert property (@(posedge clock) disable iff (srst)
        altWrite && !trig[0] && !altMerged[ALT_ACT_BIT] |=> !trig[0])
        else $error("writing zero raised activation trigger");
    a_warm_begin: assert property (@(posedge clock) disable iff (srst)
        seqState == SEQ_IDLE && trig == 3'h2 && !pathSet
        |=> seqState == SEQ_PH1 && seqKind == KIND_WARM)
        else $error("warm reset sequence did not start");
    a_warm_done: assert property (@(posedge clock) disable iff (srst)
        seqDone && seqKind == KIND_WARM && !trigSet[1]
        |=> !trig[1] && stsReg[STS_INIT_BIT])
        else $error("warm reset completion not reported");
    a_act_done: assert property (@(posedge clock) disable iff (srst)
        seqDone && seqKind == KIND_ACT && !trigSet[0]
        |=> !trig[0] && stsReg[STS_INIT_BIT] && cardPins.rstHigh)
        else $error("activation completion not reported");
    a_deact_done: assert property (@(posedge clock) disable iff (srst)
        seqDone && seqKind == KIND_DEACT && !trigSet[2]
        |=> !trig[2] && stsReg[STS_INIT_BIT] && !cardPins.power)
        else $error("deactivation completion not reported");
    a_path_clears: assert property (@(posedge clock) disable iff (srst)
        pathSet |=> trig == 3'h0 && seqState == SEQ_IDLE)
        else $error("path reset left a trigger pending");
    a_rx_selfclear: assert property (@(posedge clock) disable iff (srst)
        $rose(rxPathReset) && !altWrite
        |-> rxPathReset[*4] ##1 !rxPathReset)
        else $error("receive reset did not clear after four cycles");
    a_tx_selfclear: assert property (@(posedge clock) disable iff (srst)
        $rose(txPathReset) && !altWrite
        |-> txPathReset[*4] ##1 !txPathReset)
        else $error("transmit reset did not clear after four cycles");
    a_sync_flag: assert property (@(posedge clock) disable iff (srst)
        altWrite |=> altRead[ALT_SYNC_BIT] [*2] ##1 (altWrite
        || !altRead[ALT_SYNC_BIT]))
        else $error("sync flag timing wrong");

    c_activation: cover property (@(posedge clock) disable iff (srst)
        seqDone && seqKind == KIND_ACT);
    c_timer_expire: cover property (@(posedge clock) disable iff (srst)
        timerDone[0]);
    c_rx_reset: cover property (@(posedge clock) disable iff (srst)
        $fell(rxPathReset));
endmodule

// ==== design/smartcard_alt_pkg.sv ====
// constants, types and register map of the smart card alternate control bank
// ===========================================================================
// What this block does
// - timer run bit 0 stops timer, 1 reloads and starts it; counts ETUs
// - without auto-reload, hardware clears a timer's run bit at expiry
// - run and trigger writes are ignored while controller enable is 0
// - writing 1 to warm reset trigger starts warm reset; 0 does nothing
// - warm reset completion clears its trigger and sets init done flag
// - writing 1 to activation trigger starts activation; 0 does nothing
// - activation completion clears its trigger and sets init done flag
// - writing 1 to deactivation trigger starts deactivation; 0 does nothing
// - deactivation completion clears its trigger and sets init done flag
// - setting either path reset clears all pending sequence triggers
// - receive path reset flushes receive buffer, state machine and pointers
// - receive path reset bit clears itself when the reset has finished
// - transmit path reset flushes transmit buffer, state machine, pointers
// - sync flag bit 31 reads 1 while a write is still settling
package smartcard_alt_pkg;

    // ======================================================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFF_MAIN = 8'h00;
    localparam logic [7:0] OFF_ALT = 8'h04;
    localparam logic [7:0] OFF_TMR0 = 8'h08;
    localparam logic [7:0] OFF_TMR1 = 8'h0c;
    localparam logic [7:0] OFF_TMR2 = 8'h10;
    localparam logic [7:0] OFF_STS = 8'h14;
    localparam logic [7:0] OFF_CLR = 8'h18;
    localparam logic [7:0] OFF_IEN = 8'h1c;

    // ======================================================================
    // field positions
    localparam int MAIN_EN_BIT = 0;
    localparam int MAIN_SEL_LO = 13;
    localparam int ALT_TX_RST_BIT = 0;
    localparam int ALT_RX_RST_BIT = 1;
    localparam int ALT_DEACT_BIT = 2;
    localparam int ALT_ACT_BIT = 3;
    localparam int ALT_WARM_BIT = 4;
    localparam int ALT_RUN_LO = 5;
    localparam int ALT_ACTIVE_LO = 13;
    localparam int ALT_SYNC_BIT = 31;
    localparam int TMR_RELOAD_BIT = 26;
    localparam int STS_TMR_LO = 3;
    localparam int STS_INIT_BIT = 8;

    // ======================================================================
    // reset values and counts
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [11:0] ETU_DIV = 12'h173;
    localparam logic [15:0] SEQ_PHASE_CYCLES = 16'h0100;
    localparam logic [3:0] PATH_RESET_CYCLES = 4'h4;
    localparam logic [1:0] SYNC_CYCLES = 2'h2;

    typedef enum {SEQ_IDLE, SEQ_PH1, SEQ_PH2, SEQ_PH3} seq_state_t;
    typedef enum {KIND_ACT, KIND_WARM, KIND_DEACT} seq_kind_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic power;
        logic clkEn;
        logic rstHigh;
    } card_pins_t;

endpackage

// ==== sim/smartcard_alt_control_tb.sv ====
// self-checking bench for the alternate control bank over wishbone
`define CHECK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
    fails++; $display("Error %s expected %h seen %h", what, exp, got); end end
module smartcard_alt_control_tb;
    import smartcard_alt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock;
    logic srst;
    wb_req_t wbReq;
    logic wbAck;
    logic [31:0] wbDat;
    card_pins_t cardPins;
    logic txPathReset;
    logic rxPathReset;
    logic irq;
    int fails = 0;
    int cmp_count = 0;
    int txCnt = 0;
    int rxCnt = 0;
    int powerUps;
    int resetReleases;
    logic [31:0] rd;
    smartcard_alt_control uut (.clock(clock), .srst(srst), .wbReq(wbReq),
        .wbAck(wbAck), .wbDat(wbDat), .cardPins(cardPins),
        .txPathReset(txPathReset), .rxPathReset(rxPathReset), .irq(irq));
    smartcard_card_model card (.clock(clock), .pins(cardPins),
        .powerUps(powerUps), .resetReleases(resetReleases));
    always #10 clock = ~clock;
    always @(posedge clock) begin
        if (txPathReset === 1'b1)
            txCnt++;
        if (rxPathReset === 1'b1)
            rxCnt++;
    end
    // ======================================================================
    // bus cycles: hold the request until ack is sampled, then idle one cycle
    task automatic wb_cycle(input logic we, input logic [7:0] a,
                            input logic [31:0] d);
        int n;
        n = 0;
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        rd = wbDat;
        wbReq <= '0;
        @(posedge clock);
        if (n >= 50) begin
            fails++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_cycle(1'b1, a, d);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] mask, input logic [31:0] exp);
        wb_cycle(1'b0, a, '0);
        `CHECK(what, exp, rd & mask)
    endtask
    // poll status until the bit sets; a bounded number of reads
    task automatic wait_sts(input int idx);
        int n;
        n = 0;
        do begin
            wb_cycle(1'b0, OFF_STS, '0);
            n++;
        end while (rd[idx] !== 1'b1 && n < 700);
        `CHECK("status bit", 1'b1, rd[idx])
        if (n >= 700)
            tally_and_finish();
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ======================================================================
    // main sequence
    initial begin
        clock = 1'b0;
        srst = 1'b1;
        wbReq = '0;
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        rd_chk("alt reset", OFF_ALT, 32'hffff_ffff, REG_RESET);
        rd_chk("status reset", OFF_STS, 32'hffff_ffff, REG_RESET);
        rd_chk("unmapped", 8'h40, 32'hffff_ffff, 32'h0);
        $display("test reset done");
        // controller disabled: triggers and run bits must not stick
        wr(OFF_ALT, 32'h0000_00e8);
        rd_chk("alt disabled", OFF_ALT, 32'h0000_00fc, 32'h0);
        $display("test disabled done");
        // enable with timer selection 11
        wr(OFF_MAIN, 32'h0000_6001);
        wr(OFF_IEN, 32'h0000_0100);
        wr(OFF_ALT, 32'h0000_0008);
        rd_chk("act pending", OFF_ALT, 32'h0000_0008, 32'h8);
        wait_sts(STS_INIT_BIT);
        rd_chk("act cleared", OFF_ALT, 32'h0000_0008, 32'h0);
        `CHECK("power", 1'b1, cardPins.power)
        `CHECK("card clock on", 1'b1, cardPins.clkEn)
        `CHECK("card reset high", 1'b1, cardPins.rstHigh)
        `CHECK("card powered", 1, powerUps)
        `CHECK("irq set", 1'b1, irq)
        wr(OFF_CLR, 32'h0000_0100);
        `CHECK("irq clear", 1'b0, irq)
        wr(OFF_ALT, 32'h0000_0000);
        rd_chk("zero write", OFF_ALT, 32'h0000_001c, 32'h0);
        // a bus turnaround outlasts the settling count, so it reads 0 here
        rd_chk("sync settled", OFF_ALT, 32'h8000_0000, 32'h0);
        $display("test activation done");
        wr(OFF_ALT, 32'h0000_0010);
        wait_sts(STS_INIT_BIT);
        rd_chk("warm cleared", OFF_ALT, 32'h0000_0010, 32'h0);
        `CHECK("card reset twice", 2, resetReleases)
        wr(OFF_CLR, 32'h0000_0100);
        $display("test warm reset done");
        wr(OFF_ALT, 32'h0000_0004);
        wait_sts(STS_INIT_BIT);
        rd_chk("deact cleared", OFF_ALT, 32'h0000_0004, 32'h0);
        `CHECK("power off", 1'b0, cardPins.power)
        `CHECK("card clock off", 1'b0, cardPins.clkEn)
        `CHECK("card reset low", 1'b0, cardPins.rstHigh)
        wr(OFF_CLR, 32'h0000_0100);
        $display("test deactivation done");
        // path resets abort a pending trigger and clear themselves
        wr(OFF_ALT, 32'h0000_0008);
        txCnt = 0;
        wr(OFF_ALT, 32'h0000_0001);
        rd_chk("tx aborts", OFF_ALT, 32'h0000_0008, 32'h0);
        repeat (8) @(posedge clock);
        rd_chk("tx self clear", OFF_ALT, 32'h0000_0001, 32'h0);
        `CHECK("tx flush len", int'(PATH_RESET_CYCLES), txCnt)
        wr(OFF_ALT, 32'h0000_0010);
        rxCnt = 0;
        wr(OFF_ALT, 32'h0000_0002);
        rd_chk("rx aborts", OFF_ALT, 32'h0000_0010, 32'h0);
        repeat (8) @(posedge clock);
        rd_chk("rx self clear", OFF_ALT, 32'h0000_0002, 32'h0);
        `CHECK("rx flush len", int'(PATH_RESET_CYCLES), rxCnt)
        $display("test path reset done");
        // timers: only timer1 auto-reloads and keeps its run bit
        for (int i = 0; i < 3; i++) begin
            wr(OFF_TMR0 + 8'(4 * i), {5'h0, i == 1, 26'h2});
            wr(OFF_ALT, 32'h1 << (ALT_RUN_LO + i));
            rd_chk("timer active", OFF_ALT, 32'h1 << (ALT_ACTIVE_LO + i),
                   32'h1 << (ALT_ACTIVE_LO + i));
            wait_sts(STS_TMR_LO + i);
            rd_chk("run after expiry", OFF_ALT, 32'h1 << (ALT_RUN_LO + i),
                   (i == 1) ? 32'h1 << (ALT_RUN_LO + i) : 32'h0);
            wr(OFF_ALT, 32'h0);
            rd_chk("timer stopped", OFF_ALT, 32'h1 << (ALT_RUN_LO + i),
                   32'h0);
            wr(OFF_CLR, 32'h0000_01ff);
        end
        $display("test timers done");
        tally_and_finish();
    end
endmodule

// ==== sim/smartcard_card_model.sv ====
// card side model: watches the contact lines and counts power-up and reset
module smartcard_card_model
    import smartcard_alt_pkg::*;
(
    // clock
    input wire logic clock,
    // contact lines from the controller
    input wire smartcard_alt_pkg::card_pins_t pins,
    // event counts seen by the card
    output int powerUps,
    output int resetReleases
);
    timeunit 1ns;
    timeprecision 1ps;
    card_pins_t last;
    initial begin
        powerUps = 0;
        resetReleases = 0;
        last = '0;
    end
    // ======================================================================
    // the card only reacts to edges on its contacts; it never drives back
    always @(posedge clock) begin
        if (pins.power === 1'b1 && last.power === 1'b0)
            powerUps++;
        if (pins.rstHigh === 1'b1 && last.rstHigh === 1'b0)
            resetReleases++;
        last = pins;
    end
endmodule
